// ### hdl/nvm_sec_map.svh
// Address map, field positions, codes and reset values of the security logic.
`ifndef NVM_SEC_MAP_SVH
`define NVM_SEC_MAP_SVH

// Non-volatile options/security byte and its paged alias.
`define SEC_BYTE_ADDR 16'hff0f
`define SEC_ALIAS_ADDR 16'hbf0f
`define SEC_ALIAS_PAGE 8'h3f

// Backdoor key bytes, eight in a row.
`define KEY_BASE_ADDR 16'hff00
`define KEY_BYTES 4'h8

// Status register of this block.
`define STATUS_ADDR 16'h0100

// Sector that holds the byte, the key and the vectors.
`define SECTOR_LO_ADDR 16'hfe00
`define SECTOR_HI_ADDR 16'hffff

// Field positions inside the options/security byte.
`define KEYEN_MSB 7
`define KEYEN_LSB 6
`define NV_MSB 5
`define NV_LSB 2
`define SEC_MSB 1
`define SEC_LSB 0

// Field codes.
`define SEC_UNSECURED 2'h2
`define SEC_PREFERRED 2'h1
`define KEYEN_ENABLED 2'h2
`define KEY_WORD_ZERO 16'h0000
`define KEY_WORD_ONES 16'hffff

// Reset values; an all-zero copy reads as secured.
`define COPY_RESET 8'h00
`define KEY_RESET 64'h0000_0000_0000_0000
`define ADDR_RESET 16'h0000
`define BYTE_RESET 8'h00

`endif

// ### hdl/nvm_sec_pkg.sv
// Types shared by the security control logic.
`default_nettype none

package nvm_sec_pkg;

  // Operating mode supplied by the mode logic.
  typedef enum logic [1:0] {
    normal_single_chip_mode,
    special_single_chip_mode,
    normal_expanded_mode,
    special_expanded_mode
  } chip_mode_t;

  // Phases of the controller.
  typedef enum logic [0:0] {
    load_phase,
    run_phase
  } phase_t;

  // Complete state of the block.
  typedef struct packed {
    phase_t phase;
    logic [3:0] load_idx;
    logic [63:0] stored_key;
    logic [63:0] entered_key;
    logic [7:0] key_written;
    logic [7:0] copy;
    logic started_single_secured;
    logic backdoor_unlock;
    logic debug_unlock;
    logic bc_failed;
    logic stray;
    logic fw_mapped;
    logic [7:0] rdata;
    logic nvm_rd_req;
    logic [15:0] nvm_rd_addr;
    logic cmd_accept;
    logic cmd_refused;
    logic [15:0] erase_lo;
    logic [15:0] erase_hi;
    logic secure;
    logic debug_port_en;
    logic debug_fw_en;
    logic debug_hw_en;
    logic reg_space_only;
    logic trace_en;
    logic nvm_full_en;
    logic visibility_en;
    logic pipe_status_en;
    logic flash_sel_en;
    logic eeprom_sel_en;
  } sec_state_t;

endpackage

`default_nettype wire

// ### hdl/nvm_security_control.sv
// Security control: loads the security byte and gates debug and memories.
// What this block does
// - Every reset copies the flash options/security byte into the copy.
// - Byte layout: backdoor enable 7:6, option bits 5:2, security 1:0.
// - Only security code 10 unsecures; every other code secures.
// - Backdoor access enabled only when the enable field is 10.
// - The byte also reads at the alias when page select is 3F.
// - Secured normal single chip disables the debug port completely.
// - Secured single chip modes disable execution tracing.
// - Secured parts run only the restricted NVM command set.
// - Secured special single chip: no firmware commands, registers only.
// - Secured special reset runs blank check; pass unsecures, fail restricts.
// - All debug commands are blocked while the blank check runs.
// - Secured part moved to expanded blocks visibility and pipe status.
// - Record a secured single chip start; check PC against memory size.
// - Straying execution disables memory selects and debug until reset.
// - Matching backdoor key write unsecures in normal modes if enabled.
// - A key word of all zeros or all ones never unsecures.
// - Erasing the security byte erases its whole sector.
// - Program or erase of the byte refused while its sector is protected.
// - A reprogrammed security code takes effect only after the next reset.
// - Non-blank secured special reset leaves hardware commands to mass erase.
// - Blank memories on special reset enable every debug command.
// - Secure only when security requested and debug unlock inactive.
// - Debug unlock flag resets to zero, meaning secure.
// - Secure firmware leaves the map one cycle after unlock asserts.
`default_nettype none
`include "nvm_sec_map.svh"

module nvm_security_control (
  input wire logic sys_clk,
  input wire logic reset,
  // Register port.
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] program_page_select,
  // Flash read port used during the load.
  output logic nvm_rd_req,
  output logic [15:0] nvm_rd_addr,
  input wire logic [7:0] nvm_rd_data,
  input wire logic nvm_rd_ack,
  // Mode and execution state.
  input wire nvm_sec_pkg::chip_mode_t chip_mode,
  input wire logic [1:0] pc_high_bits,
  input wire logic [1:0] flash_base_bits,
  // Blank check run by the secure debug firmware.
  input wire logic blank_check_busy,
  input wire logic blank_check_done,
  input wire logic blank_check_pass,
  // NVM command screening.
  input wire logic nvm_cmd_req,
  input wire logic nvm_cmd_full,
  input wire logic nvm_cmd_erase,
  input wire logic [15:0] nvm_cmd_addr,
  input wire logic sector_protected,
  output logic nvm_cmd_accept,
  output logic nvm_cmd_refused,
  output logic [15:0] erase_lo_addr,
  output logic [15:0] erase_hi_addr,
  // Security effects.
  output logic secure,
  output logic backdoor_enabled,
  output logic debug_unlock_flag,
  output logic secure_fw_mapped,
  output logic debug_port_enable,
  output logic debug_fw_cmd_enable,
  output logic debug_hw_cmd_enable,
  output logic debug_reg_space_only,
  output logic trace_enable,
  output logic nvm_full_cmd_enable,
  output logic bus_visibility_enable,
  output logic instruction_pipe_status_enable,
  output logic flash_select_enable,
  output logic eeprom_select_enable
);

  // All state lives in one struct; state_d is its next value.
  nvm_sec_pkg::sec_state_t state_q;
  nvm_sec_pkg::sec_state_t state_d;

  // --------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------

  logic [1:0] security_state_field;
  logic [1:0] backdoor_enable_field;
  logic [3:0] nonvolatile_option_bits;
  logic secreq;
  logic key_enabled;

  // Decode the copy; only the exact codes unlock anything.
  assign security_state_field =
    state_q.copy[`SEC_MSB:`SEC_LSB];
  assign backdoor_enable_field =
    state_q.copy[`KEYEN_MSB:`KEYEN_LSB];
  assign nonvolatile_option_bits =
    state_q.copy[`NV_MSB:`NV_LSB];
  // Erased flash reads all ones or all zeros; both are secured codes,
  // so a blank part never comes up open.
  assign secreq = security_state_field != `SEC_UNSECURED;
  assign key_enabled = backdoor_enable_field == `KEYEN_ENABLED;

  // --------------------------------------------------------------
  // Key checks
  // --------------------------------------------------------------

  logic [3:0] word_bad;
  logic key_valid;
  logic key_match;

  // A blank or zeroed key word makes the whole key unusable.
  genvar w;
  generate
    for (w = 0; w < 4; w = w + 1) begin : g_word
      assign word_bad[w] =
        state_q.stored_key[16*w +: 16] == `KEY_WORD_ZERO ||
        state_q.stored_key[16*w +: 16] == `KEY_WORD_ONES;
    end
  endgenerate

  // Only a fully valid key is ever compared; a half blank key would
  // make guessing it far cheaper.
  assign key_valid = word_bad == 4'h0;
  assign key_match = state_q.entered_key == state_q.stored_key;

  // --------------------------------------------------------------
  // Mode and address decode
  // --------------------------------------------------------------

  logic mode_single;
  logic mode_normal;
  logic mode_special_single;
  logic in_internal;
  logic sec_read_hit;
  logic key_hit;
  logic unlock;
  logic secure_now;

  // Mode decodes. The top mode bit marks the expanded modes.
  assign mode_single =
    chip_mode == nvm_sec_pkg::normal_single_chip_mode ||
    chip_mode == nvm_sec_pkg::special_single_chip_mode;
  assign mode_normal =
    chip_mode == nvm_sec_pkg::normal_single_chip_mode ||
    chip_mode == nvm_sec_pkg::normal_expanded_mode;
  assign mode_special_single =
    chip_mode == nvm_sec_pkg::special_single_chip_mode;

  // The two top PC bits tell whether code runs from internal flash.
  // The compare is coarse on purpose: two bits split the map in quarters.
  assign in_internal = pc_high_bits >= flash_base_bits;

  // The byte answers at its own address and at the paged alias.
  assign sec_read_hit = reg_addr == `SEC_BYTE_ADDR ||
    (reg_addr == `SEC_ALIAS_ADDR &&
     program_page_select == `SEC_ALIAS_PAGE);

  // A literal cannot be sliced, so the key base is named first; the
  // eight key bytes share every address bit above the low three.
  localparam logic [15:0] key_base_addr = `KEY_BASE_ADDR;
  assign key_hit = reg_addr[15:3] == key_base_addr[15:3];

  // Either unlock path lifts security until the next reset.
  assign unlock = state_q.debug_unlock | state_q.backdoor_unlock;
  assign secure_now = secreq & ~unlock;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------

  // Every update of the block's state is worked out here.
  always_comb begin
    state_d = state_q;
    state_d.rdata = `BYTE_RESET;
    state_d.cmd_accept = 1'b0;
    state_d.cmd_refused = 1'b0;

    case (state_q.phase)
      nvm_sec_pkg::load_phase: begin
        // Key bytes first, the security byte last; the request stays up
        // through the whole load.
        state_d.nvm_rd_req = 1'b1;
        if (state_q.nvm_rd_req && nvm_rd_ack) begin
          if (state_q.load_idx < `KEY_BYTES) begin
            state_d.stored_key[8*state_q.load_idx[2:0] +: 8] =
              nvm_rd_data;
            state_d.load_idx = state_q.load_idx + 4'h1;
          end else begin
            // Apart from reset, the only place the copy is ever written.
            state_d.copy = nvm_rd_data;
            state_d.nvm_rd_req = 1'b0;
            state_d.phase = nvm_sec_pkg::run_phase;
            state_d.started_single_secured =
              (nvm_rd_data[`SEC_MSB:`SEC_LSB] != `SEC_UNSECURED) &&
              mode_single;
          end
        end
        // The address follows the updated index. Taken from the old index
        // it would lag by one, and the flash would answer the byte just
        // stored a second time.
        if (state_d.load_idx < `KEY_BYTES) begin
          state_d.nvm_rd_addr =
            {key_base_addr[15:3], state_d.load_idx[2:0]};
        end else begin
          state_d.nvm_rd_addr = `SEC_BYTE_ADDR;
        end
      end
      nvm_sec_pkg::run_phase: begin
        state_d.nvm_rd_req = 1'b0;

        // A full set of eight bytes is compared once, then the mask clears.
        if (state_q.key_written == 8'hff) begin
          state_d.key_written = 8'h00;
          if (key_match && key_valid && key_enabled && mode_normal) begin
            state_d.backdoor_unlock = 1'b1;
          end
        end
        // Backdoor key bytes are taken only where the path is open. The
        // write follows the clear, so a byte landing in the compare cycle
        // is kept for the next attempt instead of being lost.
        if (reg_write && key_hit && mode_normal && key_enabled) begin
          state_d.entered_key[8*reg_addr[2:0] +: 8] = reg_wdata;
          state_d.key_written[reg_addr[2:0]] = 1'b1;
        end

        // The blank check decides the outcome of a secured special reset.
        // Both flags hold until reset; a later passing check still unlocks after a failed one.
        if (blank_check_done && mode_special_single &&
            state_q.started_single_secured) begin
          if (blank_check_pass) begin
            state_d.debug_unlock = 1'b1;
          end else begin
            state_d.bc_failed = 1'b1;
          end
        end

        // Leaving internal flash while secured is sticky until reset.
        // Code can therefore not step out and back in unnoticed.
        if (state_q.started_single_secured && secure_now &&
            !mode_single && !in_internal) begin
          state_d.stray = 1'b1;
        end

        // Screen NVM commands.
        // The live state is used, a cycle ahead of the secure output.
        if (nvm_cmd_req) begin
          if ((nvm_cmd_full && secure_now) ||
              (nvm_cmd_addr >= `SECTOR_LO_ADDR && sector_protected)) begin
            state_d.cmd_refused = 1'b1;
          end else begin
            state_d.cmd_accept = 1'b1;
            if (nvm_cmd_erase && nvm_cmd_addr >= `SECTOR_LO_ADDR) begin
              state_d.erase_lo = `SECTOR_LO_ADDR;
              state_d.erase_hi = `SECTOR_HI_ADDR;
            end
          end
        end
      end
      default: begin
        state_d.phase = nvm_sec_pkg::load_phase;
      end
    endcase

    // Register read answer, valid in the next cycle only.
    // Unmapped addresses read zero, so no stale byte leaks out.
    if (reg_read) begin
      if (sec_read_hit) begin
        state_d.rdata = state_q.copy;
      end else if (reg_addr == `STATUS_ADDR) begin
        state_d.rdata = {state_q.stray, state_q.fw_mapped,
          state_q.bc_failed, state_q.debug_unlock,
          state_q.backdoor_unlock, state_q.started_single_secured,
          secure_now, key_enabled};
      end
    end

    // Firmware leaves the map a cycle after the unlock flag rises.
    // It is only ever mapped in special single chip mode after a secured single chip start.
    state_d.fw_mapped = state_q.started_single_secured &&
      mode_special_single && !state_q.debug_unlock;

    // Registered effects of the security state.
    // Every enable is registered, so no decode glitch reaches the pins.
    state_d.secure = secure_now;
    state_d.debug_port_en = !blank_check_busy && !state_q.stray &&
      !(secure_now &&
        chip_mode == nvm_sec_pkg::normal_single_chip_mode);
    state_d.debug_fw_en = state_d.debug_port_en &&
      !(secure_now && mode_special_single);
    state_d.debug_hw_en = state_d.debug_port_en;
    state_d.reg_space_only = secure_now;
    state_d.trace_en = !(secure_now && mode_single);
    state_d.nvm_full_en = !secure_now;
    state_d.visibility_en =
      !(state_q.started_single_secured && secure_now && !mode_single);
    state_d.pipe_status_en = state_d.visibility_en;
    state_d.flash_sel_en = !state_q.stray;
    state_d.eeprom_sel_en = !state_q.stray;
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------

  // Reset leaves the part secured until the real byte is read back.
  // Trace starts off, so nothing is traced before the first decode.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.phase <= nvm_sec_pkg::load_phase;
      state_q.copy <= `COPY_RESET;
      state_q.stored_key <= `KEY_RESET;
      state_q.entered_key <= `KEY_RESET;
      state_q.debug_unlock <= 1'b0;
      state_q.backdoor_unlock <= 1'b0;
      state_q.nvm_rd_addr <= `ADDR_RESET;
      state_q.erase_lo <= `ADDR_RESET;
      state_q.erase_hi <= `ADDR_RESET;
      state_q.secure <= 1'b1;
      state_q.trace_en <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------

  // Every output comes straight from the state register. The backdoor
  // enable decodes the registered copy, which changes only at load.
  assign reg_rdata = state_q.rdata;
  assign nvm_rd_req = state_q.nvm_rd_req;
  assign nvm_rd_addr = state_q.nvm_rd_addr;
  assign nvm_cmd_accept = state_q.cmd_accept;
  assign nvm_cmd_refused = state_q.cmd_refused;
  assign erase_lo_addr = state_q.erase_lo;
  assign erase_hi_addr = state_q.erase_hi;
  assign secure = state_q.secure;
  assign backdoor_enabled = key_enabled;
  assign debug_unlock_flag = state_q.debug_unlock;
  assign secure_fw_mapped = state_q.fw_mapped;
  assign debug_port_enable = state_q.debug_port_en;
  assign debug_fw_cmd_enable = state_q.debug_fw_en;
  assign debug_hw_cmd_enable = state_q.debug_hw_en;
  assign debug_reg_space_only = state_q.reg_space_only;
  assign trace_enable = state_q.trace_en;
  assign nvm_full_cmd_enable = state_q.nvm_full_en;
  assign bus_visibility_enable = state_q.visibility_en;
  assign instruction_pipe_status_enable = state_q.pipe_status_en;
  assign flash_select_enable = state_q.flash_sel_en;
  assign eeprom_select_enable = state_q.eeprom_sel_en;

endmodule

`default_nettype wire

// ### tb/nvm_sec_flash_model.sv
// Flash array model that answers the security load reads.
`default_nettype none
// -------------------------------------------------------------
// Flash read port model
// -------------------------------------------------------------
module nvm_sec_flash_model (
  input wire logic sys_clk,
  input wire logic nvm_rd_req,
  input wire logic [15:0] nvm_rd_addr,
  input wire logic [63:0] key,
  input wire logic [7:0] sec_byte,
  input wire logic [1:0] wait_cycles,
  output logic [7:0] nvm_rd_data = 8'h00,
  output logic nvm_rd_ack = 1'b0
);
  logic [1:0] wait_q = 2'h0;
  // Answer after a chosen number of idle cycles. Between answers the data
  // lines toggle, so a stale byte is never mistaken for a fresh one.
  always @(posedge sys_clk) begin
    nvm_rd_ack <= 1'b0;
    nvm_rd_data <= ~nvm_rd_data;
    if (nvm_rd_req && !nvm_rd_ack) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == wait_cycles) begin
        wait_q <= 2'h0;
        nvm_rd_ack <= 1'b1;
        nvm_rd_data <= (nvm_rd_addr == 16'hff0f) ? sec_byte
          : key[8 * nvm_rd_addr[2:0] +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/nvm_security_control_monitor.sv
// Concurrent checks on the security control ports.
`default_nettype none
// -------------------------------------------------------------
// Checker
// -------------------------------------------------------------
module nvm_security_control_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic nvm_rd_req,
  input wire logic [15:0] nvm_rd_addr,
  input wire nvm_sec_pkg::chip_mode_t chip_mode,
  input wire logic blank_check_busy,
  input wire logic nvm_cmd_req,
  input wire logic nvm_cmd_full,
  input wire logic nvm_cmd_erase,
  input wire logic [15:0] nvm_cmd_addr,
  input wire logic sector_protected,
  input wire logic nvm_cmd_accept,
  input wire logic nvm_cmd_refused,
  input wire logic [15:0] erase_lo_addr,
  input wire logic [15:0] erase_hi_addr,
  input wire logic secure,
  input wire logic debug_unlock_flag,
  input wire logic secure_fw_mapped,
  input wire logic debug_port_enable,
  input wire logic trace_enable
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  rst_state_a:
  assert property ($past(reset) && !reset |-> secure && !debug_unlock_flag)
    else $error("state after reset wrong");
  load_start_a:
  assert property ($past(reset) && !reset |=> nvm_rd_req
    && nvm_rd_addr == 16'hff00) else $error("load did not start");
  unlock_hold_a:
  assert property (debug_unlock_flag |=> debug_unlock_flag)
    else $error("unlock flag cleared");
  fw_unmap_a:
  assert property ($rose(debug_unlock_flag) |=> !secure_fw_mapped && !secure)
    else $error("firmware or secure not released");
  trace_off_a:
  assert property (secure && $past(secure) && !chip_mode[1]
    && $stable(chip_mode) |-> !trace_enable) else $error("trace on");
  port_off_a:
  assert property (secure && $past(secure) && $stable(chip_mode)
    && chip_mode == nvm_sec_pkg::normal_single_chip_mode
    |-> !debug_port_enable) else $error("debug port on");
  busy_block_a:
  assert property (blank_check_busy && $past(blank_check_busy)
    |-> !debug_port_enable) else $error("debug port on in blank check");
  full_refuse_a:
  assert property (nvm_cmd_req && nvm_cmd_full && secure && !nvm_rd_req
    |=> nvm_cmd_refused && !nvm_cmd_accept) else $error("full cmd taken");
  prot_refuse_a:
  assert property (nvm_cmd_req && sector_protected && !nvm_rd_req
    && nvm_cmd_addr >= 16'hfe00 |=> nvm_cmd_refused)
    else $error("protected sector cmd taken");
  erase_range_a:
  assert property (nvm_cmd_req && nvm_cmd_erase && nvm_cmd_addr >= 16'hfe00
    ##1 nvm_cmd_accept |-> erase_lo_addr == 16'hfe00
    && erase_hi_addr == 16'hffff) else $error("erase range wrong");
endmodule
bind nvm_security_control nvm_security_control_monitor mon (.sys_clk,
  .reset, .nvm_rd_req, .nvm_rd_addr, .chip_mode, .blank_check_busy,
  .nvm_cmd_req, .nvm_cmd_full, .nvm_cmd_erase, .nvm_cmd_addr,
  .sector_protected, .nvm_cmd_accept, .nvm_cmd_refused, .erase_lo_addr,
  .erase_hi_addr, .secure, .debug_unlock_flag, .secure_fw_mapped,
  .debug_port_enable, .trace_enable);
`default_nettype wire

// ### tb/tb_nvm_security_control.sv
// Self-checking bench of the security control block.
`default_nettype none
// -------------------------------------------------------------
// Bench top
// -------------------------------------------------------------
module tb_nvm_security_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, nvm_rd_data, d;
  logic [7:0] program_page_select = 8'h00;
  logic nvm_rd_req, nvm_rd_ack, nvm_cmd_accept, nvm_cmd_refused, secure;
  logic backdoor_enabled, secure_fw_mapped, debug_port_enable, trace_enable;
  logic debug_fw_cmd_enable, debug_hw_cmd_enable, debug_reg_space_only;
  logic nvm_full_cmd_enable, bus_visibility_enable, flash_select_enable;
  logic instruction_pipe_status_enable, eeprom_select_enable;
  logic [1:0] pc_high_bits = 2'h3;
  logic [15:0] nvm_rd_addr;
  nvm_sec_pkg::chip_mode_t chip_mode = nvm_sec_pkg::normal_single_chip_mode;
  logic blank_check_busy = 1'b0;
  logic blank_check_done = 1'b0;
  logic blank_check_pass = 1'b0;
  logic nvm_cmd_req = 1'b0;
  logic nvm_cmd_full = 1'b0;
  logic nvm_cmd_erase = 1'b0;
  logic [15:0] nvm_cmd_addr = 16'h0000;
  logic sector_protected = 1'b0;
  logic [7:0] sb = 8'h00;
  logic [63:0] key = 64'h0;
  logic [1:0] lat = 2'h0;
  logic [31:0] seed = 32'h61da;
  int err_count = 0;
  int comparisons = 0;

  // The program counter stays inside internal space until the last test.
  nvm_security_control dut (.sys_clk, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .program_page_select, .nvm_rd_req,
    .nvm_rd_addr, .nvm_rd_data, .nvm_rd_ack, .chip_mode,
    .pc_high_bits, .flash_base_bits(2'h2), .blank_check_busy,
    .blank_check_done, .blank_check_pass, .nvm_cmd_req, .nvm_cmd_full,
    .nvm_cmd_erase, .nvm_cmd_addr, .sector_protected, .nvm_cmd_accept,
    .nvm_cmd_refused, .erase_lo_addr(), .erase_hi_addr(), .secure,
    .backdoor_enabled, .debug_unlock_flag(), .secure_fw_mapped,
    .debug_port_enable, .debug_fw_cmd_enable, .debug_hw_cmd_enable,
    .debug_reg_space_only, .trace_enable, .nvm_full_cmd_enable,
    .bus_visibility_enable, .instruction_pipe_status_enable,
    .flash_select_enable, .eeprom_select_enable);
  nvm_sec_flash_model flash (.sys_clk, .nvm_rd_req, .nvm_rd_addr, .key,
    .sec_byte(sb), .wait_cycles(lat), .nvm_rd_data, .nvm_rd_ack);

  // Free-running 125 MHz clock.
  always #4 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic test_done();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reset with a new flash image, then wait for the load to finish.
  task automatic boot(input logic [7:0] b, input logic [63:0] k,
                      input nvm_sec_pkg::chip_mode_t m);
    logic [31:0] t;
    t = rnd();
    sb <= b;
    key <= k;
    chip_mode <= m;
    lat <= t[1:0];
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int n = 0; nvm_rd_req === 1'b1; n++) begin
      if (n > 100) begin
        err_count++;
        test_done();
      end
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [15:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  // Eight key bytes back to back, strobe held high between them.
  task automatic key_wr(input logic [63:0] k);
    for (int i = 0; i < 8; i++) begin
      reg_addr <= 16'hff00 + 16'(i);
      reg_wdata <= k[8 * i +: 8];
      reg_write <= 1'b1;
      @(posedge sys_clk);
    end
    reg_write <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  // One command; the expected answer comes from the screening model.
  task automatic cmd(input logic f, e, p, s, input logic [15:0] a);
    logic ok;
    ok = !(f && s) && !(p && a >= 16'hfe00);
    nvm_cmd_full <= f;
    nvm_cmd_erase <= e;
    nvm_cmd_addr <= a;
    sector_protected <= p;
    nvm_cmd_req <= 1'b1;
    @(posedge sys_clk);
    nvm_cmd_req <= 1'b0;
    @(posedge sys_clk);
    chk({6'h0, nvm_cmd_accept, nvm_cmd_refused}, {6'h0, ok, !ok});
  endtask

  initial begin
    logic [31:0] r;
    logic [63:0] k;
    // Every security and backdoor enable code, random option bits.
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      boot({i[3:2], r[3:0], i[1:0]}, {r, ~r}, chip_mode);
      rd(16'hff0f);
      chk(d, {i[3:2], r[3:0], i[1:0]});
      rd(16'h0100);
      chk(d & 8'h03, {6'h0, i[1:0] != 2'h2, i[3:2] == 2'h2});
      // Normal single chip: debug port, trace and full NVM set follow secure.
      chk({4'h0, trace_enable, debug_port_enable, nvm_full_cmd_enable,
        backdoor_enabled}, {4'h0, {3{i[1:0] == 2'h2}}, i[3:2] == 2'h2});
      program_page_select <= 8'h3f;
      rd(16'hbf0f);
      chk(d, {i[3:2], r[3:0], i[1:0]});
      program_page_select <= 8'h00;
      rd(16'h0200);
      chk(d, 8'h00);
      cmd(1'b1, 1'b0, 1'b0, i[1:0] != 2'h2, 16'h8000);
      sb <= 8'h02;
      rd(16'h0100);
      chk(d & 8'h02, {6'h0, i[1:0] != 2'h2, 1'b0});
    end
    // Backdoor: valid key, disabled field, zero word, all-ones word.
    for (int j = 0; j < 4; j++) begin
      r = rnd();
      // Setting a low bit and clearing the top bit of each word keeps a random key valid.
      k = {r | 32'h0101_0101, r | 32'h0202_0202} & 64'h7fff_7fff_7fff_7fff;
      if (j == 2) k[15:0] = 16'h0000;
      if (j == 3) k[47:32] = 16'hffff;
      boot(j == 1 ? 8'h41 : 8'h81, k, j == 2 ?
        nvm_sec_pkg::normal_expanded_mode : nvm_sec_pkg::normal_single_chip_mode);
      key_wr(~k);
      chk({7'h0, secure}, 8'h01);
      key_wr(k);
      chk({7'h0, secure}, {7'h0, j != 0});
      cmd(1'b1, 1'b0, 1'b0, j != 0, 16'h8000);
      cmd(1'b0, 1'b1, j[0], j != 0, 16'hfe00);
    end
    // Secured special single chip start: blank check passes, then fails.
    for (int p = 0; p < 2; p++) begin
      boot(8'h00, 64'h0, nvm_sec_pkg::special_single_chip_mode);
      blank_check_busy <= 1'b1;
      repeat (3) @(posedge sys_clk);
      blank_check_busy <= 1'b0;
      blank_check_done <= 1'b1;
      blank_check_pass <= (p == 0);
      @(posedge sys_clk);
      blank_check_done <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(16'h0100);
      chk(d & 8'h32, p == 0 ? 8'h10 : 8'h22);
      chk({4'h0, debug_fw_cmd_enable, debug_hw_cmd_enable,
        debug_reg_space_only, secure_fw_mapped},
        p == 0 ? 8'h0c : 8'h07);
    end
    // A secured single chip start moved to expanded mode, then straying.
    boot(8'h01, 64'h0, nvm_sec_pkg::normal_single_chip_mode);
    for (int s = 0; s < 2; s++) begin
      chip_mode <= nvm_sec_pkg::normal_expanded_mode;
      pc_high_bits <= s ? 2'h1 : 2'h3;
      repeat (3) @(posedge sys_clk);
      chk({3'h0, bus_visibility_enable, instruction_pipe_status_enable,
        flash_select_enable, eeprom_select_enable, debug_port_enable},
        s ? 8'h00 : 8'h07);
    end
    pc_high_bits <= 2'h3;
    rd(16'h0100);
    chk(d & 8'h84, 8'h84);
    test_done();
  end
endmodule
`default_nettype wire
